// >>> core/rmi_pkg.sv
// Register map and constants of the interrupt mask and identity bank.
// Assumes a word-aligned byte address on a plain strobe register port.
package rmi_pkg;

  // Register port widths
  localparam int unsigned RMI_ADDR_W = 12;
  localparam int unsigned RMI_DATA_W = 32;
  localparam int unsigned RMI_SRC_W = 16;
  localparam int unsigned RMI_ID_W = 16;

  // Register byte offsets
  localparam logic [11:0] RMI_OFS_STATUS = 12'h0c0;
  localparam logic [11:0] RMI_OFS_CLEAR = 12'h0c4;
  localparam logic [11:0] RMI_OFS_FORCE = 12'h0c8;
  localparam logic [11:0] RMI_OFS_MASK = 12'h0cc;
  localparam logic [11:0] RMI_OFS_NETID = 12'h100;
  localparam logic [11:0] RMI_OFS_SHORT = 12'h104;
  localparam logic [11:0] RMI_OFS_LONG_HI = 12'h108;
  localparam logic [11:0] RMI_OFS_LONG_LO = 12'h10c;

  // Source bit positions
  localparam int unsigned RMI_BIT_SEQ_DONE = 0;
  localparam int unsigned RMI_BIT_DATA_REQ = 1;
  localparam int unsigned RMI_BIT_PKT_RX = 2;
  localparam int unsigned RMI_BIT_RX_FILL = 9;
  localparam int unsigned RMI_BIT_SOFT_CLK = 10;
  localparam int unsigned RMI_BIT_FLT_FAIL = 11;
  localparam int unsigned RMI_BIT_CRC_FAIL = 12;
  localparam int unsigned RMI_BIT_CMPL_CLK = 13;
  localparam int unsigned RMI_BIT_FRAME_ST = 14;
  localparam int unsigned RMI_BIT_SEQ_START = 15;

  // Implemented source bits; the rest are reserved
  localparam logic [15:0] RMI_SRC_VALID = 16'hfe07;

  // Values after reset
  localparam logic [15:0] RMI_RST_MASK = 16'h0000;
  localparam logic [15:0] RMI_RST_PEND = 16'h0000;
  localparam logic [15:0] RMI_RST_NETID = 16'hffff;
  localparam logic [15:0] RMI_RST_SHORT = 16'hffff;
  localparam logic [31:0] RMI_RST_LONG = 32'h0000_0000;
  localparam logic [31:0] RMI_RD_UNMAPPED = 32'h0000_0000;

endpackage

// >>> core/rmi_regs.sv
// Interrupt pending, clear, force and mask registers plus identity registers.
// Assumes single-cycle strobes, never both at once, and one-cycle event pulses.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module rmi_regs
  import rmi_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Event pulses from source logic
  input wire logic [15:0] i_evt,
  // Interrupt to processor
  output logic o_irq,
  // Identity to header filter
  output logic [15:0] o_network_id,
  output logic [15:0] o_short_addr,
  output logic [63:0] o_long_addr
);

  // Address decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [15:0] mask;
  logic [15:0] pend;
  logic [15:0] next_mask;
  logic [15:0] next_pend;
  logic [15:0] next_network_id;
  logic [15:0] next_short_addr;
  logic [63:0] next_long_addr;
  logic [31:0] next_rdata;
  logic next_irq;
  logic [15:0] clr_bits;
  logic [15:0] set_bits;
  logic wr_en;
  logic rd_en;

  assign wr_en = i_wr & i_clk_en;
  assign rd_en = i_rd & i_clk_en;

  // Clear and force strobes
  always_comb begin
    clr_bits = 16'h0000;
    set_bits = i_evt & RMI_SRC_VALID;
    if (wr_en && hit(i_addr, RMI_OFS_CLEAR)) begin
      clr_bits = i_wdata[15:0] & RMI_SRC_VALID;
    end
    if (wr_en && hit(i_addr, RMI_OFS_FORCE)) begin
      set_bits = set_bits | (i_wdata[15:0] & RMI_SRC_VALID);
    end
  end

  // Pending bits, set wins over clear
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pend
      always_comb begin
        next_pend[g] = pend[g];
        if (i_clk_en) begin
          next_pend[g] = set_bits[g] | (pend[g] & ~clr_bits[g]);
        end
      end
    end
  endgenerate

  // Software register writes
  always_comb begin
    next_mask = mask;
    next_network_id = o_network_id;
    next_short_addr = o_short_addr;
    next_long_addr = o_long_addr;
    if (wr_en) begin
      if (hit(i_addr, RMI_OFS_MASK)) begin
        next_mask = i_wdata[15:0] & RMI_SRC_VALID;
      end
      if (hit(i_addr, RMI_OFS_NETID)) begin
        next_network_id = i_wdata[15:0];
      end
      if (hit(i_addr, RMI_OFS_SHORT)) begin
        next_short_addr = i_wdata[15:0];
      end
      if (hit(i_addr, RMI_OFS_LONG_HI)) begin
        next_long_addr[63:32] = i_wdata;
      end
      if (hit(i_addr, RMI_OFS_LONG_LO)) begin
        next_long_addr[31:0] = i_wdata;
      end
    end
  end

  // Interrupt line from current pending and mask
  always_comb begin
    next_irq = o_irq;
    if (i_clk_en) begin
      next_irq = |(pend & mask);
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = o_rdata;
    if (i_clk_en) begin
      next_rdata = RMI_RD_UNMAPPED;
      if (rd_en) begin
        case (i_addr)
          RMI_OFS_STATUS: next_rdata = {16'h0000, pend};
          RMI_OFS_MASK: next_rdata = {16'h0000, mask};
          RMI_OFS_NETID: next_rdata = {16'h0000, o_network_id};
          RMI_OFS_SHORT: next_rdata = {16'h0000, o_short_addr};
          RMI_OFS_LONG_HI: next_rdata = o_long_addr[63:32];
          RMI_OFS_LONG_LO: next_rdata = o_long_addr[31:0];
          default: next_rdata = RMI_RD_UNMAPPED;
        endcase
      end
    end
  end

  // State registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mask <= RMI_RST_MASK;
      pend <= RMI_RST_PEND;
      o_irq <= 1'b0;
      o_rdata <= RMI_RD_UNMAPPED;
      o_network_id <= RMI_RST_NETID;
      o_short_addr <= RMI_RST_SHORT;
      o_long_addr <= {RMI_RST_LONG, RMI_RST_LONG};
    end else begin
      mask <= next_mask;
      pend <= next_pend;
      o_irq <= next_irq;
      o_rdata <= next_rdata;
      o_network_id <= next_network_id;
      o_short_addr <= next_short_addr;
      o_long_addr <= next_long_addr;
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  irq_follow_a: assert property (
    i_clk_en |=> (o_irq == $past(|(pend & mask))))
  else $error("irq does not follow pending and mask");

  irq_cause_a: assert property (
    $rose(o_irq) |-> $past(|(pend & mask)))
  else $error("irq raised without enabled pending source");

  irq_frozen_a: assert property (
    !i_clk_en |=> $stable(o_irq) && $stable(pend) && $stable(mask))
  else $error("state moved with clock enable low");

  reset_vals_a: assert property (
    $past(i_sys_rst) |-> (mask == 16'h0000) && (o_network_id == 16'hffff)
      && (o_short_addr == 16'hffff) && (o_long_addr == 64'h0) && !o_irq)
  else $error("wrong values after reset");

  mask_write_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_MASK) |=> mask == ($past(i_wdata[15:0]) & 16'hfe07))
  else $error("mask write not stored");

  mask_resv_a: assert property (
    (mask & 16'h01f8) == 16'h0000)
  else $error("reserved mask bit set");

  clear_bits_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_CLEAR) |=> (pend & $past(i_wdata[15:0] & ~i_evt)) == 16'h0000)
  else $error("clear write left pending bit");

  clear_keep_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_CLEAR) |=> (pend & $past(~i_wdata[15:0] & pend)) == $past(~i_wdata[15:0] & pend))
  else $error("zero clear bit changed pending");

  force_bits_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_FORCE) |=>
      (pend & $past(i_wdata[15:0] & RMI_SRC_VALID)) == $past(i_wdata[15:0] & RMI_SRC_VALID))
  else $error("force write did not set pending");

  event_wins_a: assert property (
    i_clk_en && (i_evt[RMI_BIT_SEQ_DONE] == 1'b1) |=> pend[RMI_BIT_SEQ_DONE])
  else $error("event lost");

  netid_write_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_NETID) |=> o_network_id == $past(i_wdata[15:0]))
  else $error("network id write not stored");

  short_write_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_SHORT) |=> o_short_addr == $past(i_wdata[15:0]))
  else $error("short address write not stored");

  long_hi_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_LONG_HI) |=>
      (o_long_addr[63:32] == $past(i_wdata)) && $stable(o_long_addr[31:0]))
  else $error("upper long address write wrong");

  long_lo_a: assert property (
    wr_en && hit(i_addr, RMI_OFS_LONG_LO) |=>
      (o_long_addr[31:0] == $past(i_wdata)) && $stable(o_long_addr[63:32]))
  else $error("lower long address write wrong");

  read_mask_a: assert property (
    rd_en && hit(i_addr, RMI_OFS_MASK) |=> o_rdata == {16'h0000, $past(mask)})
  else $error("mask read wrong");

  read_once_a: assert property (
    i_clk_en && !i_rd ##1 i_clk_en |-> o_rdata == 32'h0000_0000)
  else $error("read data stands beyond one cycle");

  read_status_a: assert property (
    rd_en && hit(i_addr, RMI_OFS_STATUS) |=> o_rdata == {16'h0000, $past(pend)})
  else $error("status read wrong");

  read_netid_a: assert property (
    rd_en && hit(i_addr, RMI_OFS_NETID) |=> o_rdata == {16'h0000, $past(o_network_id)})
  else $error("network id read wrong");

  read_short_a: assert property (
    rd_en && hit(i_addr, RMI_OFS_SHORT) |=> o_rdata == {16'h0000, $past(o_short_addr)})
  else $error("short address read wrong");

  read_upper_a: assert property (
    rd_en && hit(i_addr, RMI_OFS_LONG_HI) |=> o_rdata == $past(o_long_addr[63:32]))
  else $error("upper long address read wrong");

  read_lower_a: assert property (
    rd_en && hit(i_addr, RMI_OFS_LONG_LO) |=> o_rdata == $past(o_long_addr[31:0]))
  else $error("lower long address read wrong");

  read_set_clr_a: assert property (
    rd_en && (hit(i_addr, RMI_OFS_CLEAR) || hit(i_addr, RMI_OFS_FORCE)) |=> o_rdata == 32'h0000_0000)
  else $error("clear or force register read not zero");

  read_unaligned_a: assert property (
    rd_en && (i_addr[1:0] != 2'b00) |=> o_rdata == 32'h0000_0000)
  else $error("unaligned read not zero");

  ids_frozen_a: assert property (
    !i_clk_en |=> $stable(o_network_id) && $stable(o_short_addr)
      && $stable(o_long_addr) && $stable(o_rdata))
  else $error("register moved with clock enable low");

  mask_keep_a: assert property (
    !(wr_en && hit(i_addr, RMI_OFS_MASK)) |=> $stable(mask))
  else $error("mask changed without a mask write");

  irq_masked_a: assert property (
    i_clk_en && ((pend & mask) == 16'h0000) |=> !o_irq)
  else $error("irq raised with no enabled pending source");

  // Event to irq through each source's own mask bit
  seq_start_a: assert property (
    i_clk_en && i_evt[RMI_BIT_SEQ_START] ##1 i_clk_en && mask[RMI_BIT_SEQ_START] |=> o_irq)
  else $error("sequence started event gave no irq");

  frame_start_a: assert property (
    i_clk_en && i_evt[RMI_BIT_FRAME_ST] ##1 i_clk_en && mask[RMI_BIT_FRAME_ST] |=> o_irq)
  else $error("frame start event gave no irq");

  cmpl_clock_a: assert property (
    i_clk_en && i_evt[RMI_BIT_CMPL_CLK] ##1 i_clk_en && mask[RMI_BIT_CMPL_CLK] |=> o_irq)
  else $error("completion clock event gave no irq");

  soft_clock_a: assert property (
    i_clk_en && i_evt[RMI_BIT_SOFT_CLK] ##1 i_clk_en && mask[RMI_BIT_SOFT_CLK] |=> o_irq)
  else $error("soft completion clock event gave no irq");

  crc_fail_a: assert property (
    i_clk_en && i_evt[RMI_BIT_CRC_FAIL] ##1 i_clk_en && mask[RMI_BIT_CRC_FAIL] |=> o_irq)
  else $error("checksum failure event gave no irq");

  filter_fail_a: assert property (
    i_clk_en && i_evt[RMI_BIT_FLT_FAIL] ##1 i_clk_en && mask[RMI_BIT_FLT_FAIL] |=> o_irq)
  else $error("header filter failure event gave no irq");

  rx_fill_a: assert property (
    i_clk_en && i_evt[RMI_BIT_RX_FILL] ##1 i_clk_en && mask[RMI_BIT_RX_FILL] |=> o_irq)
  else $error("receive fill event gave no irq");

  pkt_rx_a: assert property (
    i_clk_en && i_evt[RMI_BIT_PKT_RX] ##1 i_clk_en && mask[RMI_BIT_PKT_RX] |=> o_irq)
  else $error("packet received event gave no irq");

  data_req_a: assert property (
    i_clk_en && i_evt[RMI_BIT_DATA_REQ] ##1 i_clk_en && mask[RMI_BIT_DATA_REQ] |=> o_irq)
  else $error("data request event gave no irq");

  seq_done_a: assert property (
    i_clk_en && i_evt[RMI_BIT_SEQ_DONE] ##1 i_clk_en && mask[RMI_BIT_SEQ_DONE] |=> o_irq)
  else $error("sequence done event gave no irq");

  // Gating of each implemented source by its own mask bit; reserved sources never pend
  generate
    for (g = 0; g < 16; g++) begin : g_chk
      if (RMI_SRC_VALID[g]) begin : g_src
        src_gate_a: assert property (
          i_clk_en && pend[g] && mask[g] |=> o_irq)
        else $error("enabled pending source gave no irq");
      end else begin : g_resv
        src_resv_a: assert property (
          !pend[g])
        else $error("reserved source pending");
      end
    end
  endgenerate

  cov_start_c: cover property (
    i_clk_en && i_evt[RMI_BIT_SEQ_START] && mask[RMI_BIT_SEQ_START] ##2 o_irq);
  cov_force_c: cover property (
    wr_en && hit(i_addr, RMI_OFS_FORCE) ##1 pend[RMI_BIT_DATA_REQ]);
  cov_clear_c: cover property (
    o_irq && wr_en && hit(i_addr, RMI_OFS_CLEAR) ##2 !o_irq);
  cov_race_c: cover property (
    wr_en && hit(i_addr, RMI_OFS_CLEAR) && |(i_wdata[15:0] & i_evt));
  cov_reset_c: cover property (
    $past(i_sys_rst) && !$past(i_clk_en));

endmodule

// >>> testbench/rmi_regs_tb_top.sv
// Self-checking bench for the interrupt mask and identity register bank.
// Assumes the bench drives every port itself over the plain strobe register port.
`timescale 1ns/1ps

module rmi_regs_tb_top
  import rmi_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_evt = 16'h0000;
  logic [31:0] o_rdata;
  logic o_irq;
  logic [15:0] o_network_id;
  logic [15:0] o_short_addr;
  logic [63:0] o_long_addr;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] bit_val;

  rmi_regs i_dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_evt(i_evt), .o_irq(o_irq), .o_network_id(o_network_id),
    .o_short_addr(o_short_addr), .o_long_addr(o_long_addr)
  );

  always #25 i_sys_clk = ~i_sys_clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk({32'h0, o_rdata}, {32'h0, exp});
  endtask

  // Irq one edge after the cause lands
  task automatic irq_is(input logic exp);
    @(posedge i_sys_clk);
    #1;
    chk({63'h0, o_irq}, {63'h0, exp});
  endtask

  task automatic wrap_up();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge i_sys_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    // Reset values
    rd(RMI_OFS_MASK, 32'h0000_0000);
    rd(RMI_OFS_NETID, 32'h0000_ffff);
    rd(RMI_OFS_SHORT, 32'h0000_ffff);
    rd(RMI_OFS_LONG_HI, 32'h0000_0000);
    rd(RMI_OFS_LONG_LO, 32'h0000_0000);
    chk({32'h0, o_network_id, o_short_addr}, 64'h0000_0000_ffff_ffff);
    chk(o_long_addr, 64'h0);
    // Reserved mask bits and unmapped place
    wr(RMI_OFS_MASK, 32'hffff_ffff);
    rd(RMI_OFS_MASK, {16'h0, RMI_SRC_VALID});
    wr(12'h1f0, 32'h1234_5678);
    rd(12'h1f0, RMI_RD_UNMAPPED);
    rd(12'h0cd, RMI_RD_UNMAPPED);
    // Reserved events never pend
    @(posedge i_sys_clk);
    i_evt <= ~RMI_SRC_VALID;
    @(posedge i_sys_clk);
    i_evt <= 16'h0000;
    irq_is(1'b0);
    rd(RMI_OFS_STATUS, 32'h0000_0000);
    // Identity registers
    wr(RMI_OFS_NETID, 32'hdead_5678);
    wr(RMI_OFS_SHORT, 32'hbeef_9abc);
    wr(RMI_OFS_LONG_HI, 32'h89ab_cdef);
    wr(RMI_OFS_LONG_LO, 32'h0123_4567);
    rd(RMI_OFS_NETID, 32'h0000_5678);
    rd(RMI_OFS_SHORT, 32'h0000_9abc);
    rd(RMI_OFS_LONG_HI, 32'h89ab_cdef);
    rd(RMI_OFS_LONG_LO, 32'h0123_4567);
    chk({32'h0, o_network_id, o_short_addr}, 64'h0000_0000_5678_9abc);
    chk(o_long_addr, 64'h89ab_cdef_0123_4567);
    // Writes with clock enable low are ignored
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    wr(RMI_OFS_NETID, 32'h0000_1111);
    i_clk_en <= 1'b1;
    rd(RMI_OFS_NETID, 32'h0000_5678);
    // Each source: masked out, then enabled, then cleared
    for (int b = 0; b < 16; b++) begin
      if (RMI_SRC_VALID[b]) begin
        bit_val = 32'h1 << b;
        wr(RMI_OFS_MASK, ~bit_val);
        wr(RMI_OFS_FORCE, bit_val);
        irq_is(1'b0);
        rd(RMI_OFS_STATUS, bit_val);
        wr(RMI_OFS_MASK, bit_val);
        irq_is(1'b1);
        wr(RMI_OFS_CLEAR, 32'h0000_0000);
        irq_is(1'b1);
        wr(RMI_OFS_CLEAR, bit_val);
        irq_is(1'b0);
        rd(RMI_OFS_STATUS, 32'h0000_0000);
        @(posedge i_sys_clk);
        i_evt <= bit_val[15:0];
        @(posedge i_sys_clk);
        i_evt <= 16'h0000;
        irq_is(1'b1);
        wr(RMI_OFS_CLEAR, bit_val);
      end
    end
    // Event pulse path, then mask bit turned off
    wr(RMI_OFS_MASK, 32'h0000_8001);
    wr(RMI_OFS_FORCE, 32'h0000_8000);
    @(posedge i_sys_clk);
    i_evt <= 16'h0001;
    @(posedge i_sys_clk);
    i_evt <= 16'h0000;
    irq_is(1'b1);
    rd(RMI_OFS_STATUS, 32'h0000_8001);
    wr(RMI_OFS_MASK, 32'h0000_0000);
    irq_is(1'b0);
    // Event and its clear in one cycle: the event wins
    wr(RMI_OFS_CLEAR, 32'h0000_ffff);
    wr(RMI_OFS_MASK, 32'h0000_8000);
    @(posedge i_sys_clk);
    i_evt <= 16'h8000;
    i_wr <= 1'b1;
    i_addr <= RMI_OFS_CLEAR;
    i_wdata <= 32'h0000_8000;
    @(posedge i_sys_clk);
    i_evt <= 16'h0000;
    i_wr <= 1'b0;
    irq_is(1'b1);
    rd(RMI_OFS_STATUS, 32'h0000_8000);
    // Reset acts with the clock enable low
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    i_sys_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    i_clk_en <= 1'b1;
    rd(RMI_OFS_STATUS, 32'h0000_0000);
    rd(RMI_OFS_MASK, 32'h0000_0000);
    irq_is(1'b0);
    chk({32'h0, o_network_id, o_short_addr}, 64'h0000_0000_ffff_ffff);
    chk(o_long_addr, 64'h0);
    rd(RMI_OFS_CLEAR, 32'h0000_0000);
    wrap_up();
  end
endmodule
